// File: rtl/bic_bridge_regs.sv
// Purpose: vendor/device identifiers and low command bits of a switch port bridge header
// Assumes: one configuration access at a time, held until cfg_ack_o
// Notes:   classification of requests and window hits comes from the port's decoders
`timescale 1ns/100ps
`include "bic_defs.svh"

module bic_bridge_regs #(
  parameter logic [15:0] VENDOR_CODE = 16'h0a5a, // arbitrary neutral value
  parameter logic [15:0] DEVICE_CODE = 16'h0c3c  // arbitrary neutral value
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   cfg_req_i,
  input  wire logic                   cfg_wr_i,
  input  wire logic [`BIC_ADDR_W-1:0] cfg_addr_i,
  input  wire logic [3:0]             cfg_byte_en_i,
  input  wire logic [31:0]            cfg_wdata_i,
  output logic      [31:0]            cfg_rdata_o,
  output logic                        cfg_ack_o,
  input  wire logic                   pri_req_valid_i,
  input  wire bic_pkg::bic_req_e      pri_req_kind_i,
  input  wire logic                   pri_in_io_win_i,
  input  wire logic                   pri_in_mem_win_i,
  output logic                        pri_claim_o,
  input  wire logic                   up_req_valid_i,
  input  wire bic_pkg::bic_req_e      up_req_kind_i,
  input  wire logic                   up_nonposted_i,
  output logic                        up_forward_o,
  output logic                        up_ur_o,
  output logic                        up_ur_cpl_o,
  output logic                        io_space_enable_o,
  output logic                        memory_space_enable_o,
  output logic                        request_forwarding_enable_o
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration access: one-cycle ack after each cycle in which a request is taken

  bic_pkg::bic_cmd_t bridge_command;
  bic_pkg::bic_cmd_t next_bridge_command;
  logic [31:0]       next_cfg_rdata;
  logic              next_cfg_ack;
  logic [9:0]        dw_index;
  logic              take;

  assign dw_index = cfg_addr_i[`BIC_ADDR_W-1:2];
  // a request held across its ack cycle is not taken twice
  assign take     = cfg_req_i && !cfg_ack_o;

  // read mux and command update; unmapped dwords read zero and drop writes
  always_comb begin
    next_bridge_command = bridge_command;
    next_cfg_rdata      = cfg_rdata_o;
    next_cfg_ack        = take;
    if (take) begin
      next_cfg_rdata = `BIC_RDATA_RESET;
      if (dw_index == `BIC_DW_IDENT) begin
        next_cfg_rdata = {DEVICE_CODE, VENDOR_CODE};
      end else if (dw_index == `BIC_DW_COMMAND) begin
        // bits 4:3 and upper bits stay zero: no flop behind them
        next_cfg_rdata = {29'h0, bridge_command};
        if (cfg_wr_i && cfg_byte_en_i[0]) begin
          next_bridge_command = cfg_wdata_i[`BIC_CMD_FWD_BIT:`BIC_CMD_IO_BIT];
        end
      end
      if (cfg_wr_i) begin
        next_cfg_rdata = `BIC_RDATA_RESET;
      end
    end
  end

  // read data holds between accesses, so a slow master may pick it up late
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      bridge_command <= `BIC_CMD_RESET;
      cfg_rdata_o    <= `BIC_RDATA_RESET;
      cfg_ack_o      <= 1'b0;
    end else begin
      bridge_command <= next_bridge_command;
      cfg_rdata_o    <= next_cfg_rdata;
      cfg_ack_o      <= next_cfg_ack;
    end
  end

  assign io_space_enable_o           = bridge_command[`BIC_CMD_IO_BIT];
  assign memory_space_enable_o       = bridge_command[`BIC_CMD_MEM_BIT];
  assign request_forwarding_enable_o = bridge_command[`BIC_CMD_FWD_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // forwarding decisions: combinational, so a new enable acts from the
  // cycle in which the write is acknowledged

  logic up_gated;

  // primary side claims only window hits of an enabled space
  always_comb begin
    pri_claim_o = 1'b0;
    if (pri_req_valid_i) begin
      if (pri_req_kind_i == bic_pkg::BIC_REQ_IO) begin
        pri_claim_o = pri_in_io_win_i && io_space_enable_o;
      end else if (pri_req_kind_i == bic_pkg::BIC_REQ_MEM) begin
        pri_claim_o = pri_in_mem_win_i && memory_space_enable_o;
      end
    end
  end

  // only memory, I/O and MSI requests are gated; completions and messages pass
  assign up_gated = (up_req_kind_i == bic_pkg::BIC_REQ_MEM) ||
                    (up_req_kind_i == bic_pkg::BIC_REQ_IO)  ||
                    (up_req_kind_i == bic_pkg::BIC_REQ_MSI);

  always_comb begin
    up_forward_o = 1'b0;
    up_ur_o      = 1'b0;
    up_ur_cpl_o  = 1'b0;
    if (up_req_valid_i) begin
      if (up_gated && !request_forwarding_enable_o) begin
        up_ur_o     = 1'b1;
        up_ur_cpl_o = up_nonposted_i;
      end else begin
        up_forward_o = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // access checks look one edge after the taking edge, where the answer stands;
  // decision checks are same-cycle because the gating is combinational

  property p_ident_read;
    @(posedge core_clk_i) disable iff (srst_i)
      (take && !cfg_wr_i && dw_index == `BIC_DW_IDENT) |=> cfg_ack_o &&
        cfg_rdata_o == {DEVICE_CODE, VENDOR_CODE};
  endproperty
  a_ident_read: assert property (p_ident_read) else $error("ident read wrong");

  property p_device_half;
    @(posedge core_clk_i) disable iff (srst_i)
      (take && !cfg_wr_i && dw_index == `BIC_DW_IDENT) |=> cfg_rdata_o[31:16] == DEVICE_CODE;
  endproperty
  a_device_half: assert property (p_device_half) else $error("device id wrong");

  property p_io_gate;
    @(posedge core_clk_i) disable iff (srst_i)
      (pri_req_valid_i && pri_req_kind_i == bic_pkg::BIC_REQ_IO && !bridge_command[0])
        |-> !pri_claim_o;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("io claimed while disabled");

  property p_io_open;
    @(posedge core_clk_i) disable iff (srst_i)
      (pri_req_valid_i && pri_req_kind_i == bic_pkg::BIC_REQ_IO && pri_in_io_win_i &&
       bridge_command[0]) |-> pri_claim_o;
  endproperty
  a_io_open: assert property (p_io_open) else $error("enabled io hit not claimed");

  property p_mem_gate;
    @(posedge core_clk_i) disable iff (srst_i)
      (pri_req_valid_i && pri_req_kind_i == bic_pkg::BIC_REQ_MEM && pri_in_mem_win_i)
        |-> pri_claim_o == bridge_command[1];
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("mem claim mismatch");

  property p_fwd_block;
    @(posedge core_clk_i) disable iff (srst_i)
      (up_req_valid_i && up_gated && !bridge_command[2]) |-> up_ur_o && !up_forward_o;
  endproperty
  a_fwd_block: assert property (p_fwd_block) else $error("blocked request forwarded");

  property p_ur_cpl;
    @(posedge core_clk_i) disable iff (srst_i)
      up_ur_cpl_o |-> up_nonposted_i && !bridge_command[2];
  endproperty
  a_ur_cpl: assert property (p_ur_cpl) else $error("ur completion misplaced");

  property p_cpl_free;
    @(posedge core_clk_i) disable iff (srst_i)
      (up_req_valid_i && (up_req_kind_i == bic_pkg::BIC_REQ_CPL ||
       up_req_kind_i == bic_pkg::BIC_REQ_OTHER)) |-> up_forward_o && !up_ur_o;
  endproperty
  a_cpl_free: assert property (p_cpl_free) else $error("completion gated");

  property p_ro_zero;
    @(posedge core_clk_i) disable iff (srst_i)
      (take && !cfg_wr_i && dw_index == `BIC_DW_COMMAND) |=> cfg_rdata_o[31:3] == 29'h0;
  endproperty
  a_ro_zero: assert property (p_ro_zero) else $error("read-only command bits set");

  property p_write_effect;
    @(posedge core_clk_i) disable iff (srst_i)
      (take && cfg_wr_i && dw_index == `BIC_DW_COMMAND && cfg_byte_en_i[0])
        |=> bridge_command == $past(cfg_wdata_i[2:0]) && cfg_ack_o;
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("command write lost");

  property p_reset_clear;
    @(posedge core_clk_i) srst_i |=> bridge_command == 3'h0 && !cfg_ack_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong");

  c_cmd_write: cover property (@(posedge core_clk_i) disable iff (srst_i)
    take && cfg_wr_i && dw_index == `BIC_DW_COMMAND);
  c_ur_cpl:    cover property (@(posedge core_clk_i) disable iff (srst_i) up_ur_cpl_o);
  c_fwd_open:  cover property (@(posedge core_clk_i) disable iff (srst_i)
    up_forward_o && up_gated);
  c_io_claim:  cover property (@(posedge core_clk_i) disable iff (srst_i)
    pri_claim_o && pri_req_kind_i == bic_pkg::BIC_REQ_IO);

endmodule

// File: rtl/bic_defs.svh
// Purpose: offsets, field positions and reset values of the bridge id and command bank
// Assumes: configuration byte addresses, one aligned dword per access
// Notes:   definitions only
`ifndef BIC_DEFS_SVH
`define BIC_DEFS_SVH

`define BIC_ADDR_W          12
`define BIC_OFF_VENDOR      12'h000
`define BIC_OFF_DEVICE      12'h002
`define BIC_OFF_COMMAND     12'h004
`define BIC_DW_IDENT        10'h000
`define BIC_DW_COMMAND      10'h001
`define BIC_CMD_IO_BIT      0
`define BIC_CMD_MEM_BIT     1
`define BIC_CMD_FWD_BIT     2
`define BIC_CMD_SPECIAL_BIT 3
`define BIC_CMD_MWI_BIT     4
`define BIC_CMD_RESET       3'h0
`define BIC_RDATA_RESET     32'h0000_0000

`endif

// File: rtl/bic_pkg.sv
// Purpose: types shared by the bridge id and command bank
// Assumes: nothing
// Notes:   request kinds as seen by the forwarding decisions
package bic_pkg;
  typedef enum logic [2:0] {
    BIC_REQ_MEM   = 3'h0,
    BIC_REQ_IO    = 3'h1,
    BIC_REQ_MSI   = 3'h2,
    BIC_REQ_CPL   = 3'h3,
    BIC_REQ_OTHER = 3'h4
  } bic_req_e;
  typedef logic [2:0] bic_cmd_t;
endpackage

// File: tb/bic_root_model.sv
// Purpose: upstream requester issuing configuration accesses to the bank
// Assumes: called 1 ns after a rising edge; one access at a time
// Notes:   released request, write, address and data lines show the inverse so stale values are never trusted; byte enables hold
`timescale 1ns/100ps
module bic_root_model (
  input  wire logic        core_clk_i,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i,
  output logic             cfg_req_o,
  output logic             cfg_wr_o,
  output logic [11:0]      cfg_addr_o,
  output logic [3:0]       cfg_byte_en_o,
  output logic [31:0]      cfg_wdata_o,
  output logic             timed_out_o
);
  initial begin
    cfg_req_o     = 1'b0;
    cfg_wr_o      = 1'b0;
    cfg_addr_o    = 12'hfff;
    cfg_byte_en_o = 4'h0;
    cfg_wdata_o   = 32'h0;
    timed_out_o   = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // hold the request through the edge that samples the ack, then let go
  task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    // one edge passes after the previous release, so no line is set twice in a step
    @(posedge core_clk_i);
    #1;
    {cfg_req_o, cfg_wr_o, cfg_addr_o, cfg_byte_en_o, cfg_wdata_o} = {1'b1, wr, addr, be, wd};
    do begin
      @(posedge core_clk_i);
      #1;
      n++;
    end while (cfg_ack_i !== 1'b1 && n < 20);
    timed_out_o = (cfg_ack_i !== 1'b1);
    rd = cfg_rdata_i;
    @(posedge core_clk_i);
    #1;
    {cfg_req_o, cfg_wr_o, cfg_addr_o, cfg_wdata_o} = {1'b0, ~wr, ~addr, ~wd};
  endtask
endmodule

// File: tb/bic_bridge_regs_test.sv
// Purpose: self-checking bench for the bridge id and command bank
// Assumes: inputs change 1 ns after the rising edge
// Notes:   decisions are swept over every command value and request kind
`timescale 1ns/100ps
module bic_bridge_regs_test;
  localparam logic [15:0] VEND = 16'h5a01; // arbitrary value
  localparam logic [15:0] DEVC = 16'h3c02; // arbitrary value
  logic              core_clk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic              req, wr, ack, tmo, pv, pio, pmem, claim, uv, unp, fwd, ur, urc;
  logic              ioe, meme, fwde;
  logic [11:0]       addr;
  logic [3:0]        be;
  logic [31:0]       wd, rd, rv;
  bic_pkg::bic_req_e pk;
  int                fails = 0;
  int                checks_done = 0;
  initial forever #5 core_clk_i = ~core_clk_i;
  initial begin
    {pv, pio, pmem, uv, unp} = 5'h00;
    pk = bic_pkg::BIC_REQ_MEM;
  end
  bic_bridge_regs #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEVC)) bic_bridge_regs_i (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .cfg_req_i(req), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_byte_en_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rd),
    .cfg_ack_o(ack), .pri_req_valid_i(pv), .pri_req_kind_i(pk), .pri_in_io_win_i(pio),
    .pri_in_mem_win_i(pmem), .pri_claim_o(claim), .up_req_valid_i(uv), .up_req_kind_i(pk),
    .up_nonposted_i(unp), .up_forward_o(fwd), .up_ur_o(ur), .up_ur_cpl_o(urc),
    .io_space_enable_o(ioe), .memory_space_enable_o(meme),
    .request_forwarding_enable_o(fwde));
  bic_root_model bic_root_model_i (
    .core_clk_i(core_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rd), .cfg_req_o(req),
    .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_byte_en_o(be), .cfg_wdata_o(wd),
    .timed_out_o(tmo));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // a hung access counts as a failure and closes the run
  task automatic rc(logic w, logic [11:0] a, logic [3:0] b, logic [31:0] d);
    bic_root_model_i.access(w, a, b, d, rv);
    if (tmo !== 1'b0) begin
      fails++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    check("en_rst", {fwde, meme, ioe}, 32'h0);
    rc(1'b0, 12'h000, 4'hf, 32'h0);
    check("ids", rv, {DEVC, VEND});
    rc(1'b1, 12'h000, 4'hf, 32'hffff_ffff);
    rc(1'b0, 12'h002, 4'hf, 32'h0);
    check("ids_wr", rv, {DEVC, VEND});
    rc(1'b0, 12'h004, 4'hf, 32'h0);
    check("cmd_rst", rv, 32'h0);
    rc(1'b1, 12'h004, 4'hf, 32'hffff_ffff);
    rc(1'b0, 12'h004, 4'hf, 32'h0);
    check("cmd_ro", rv, 32'h7);
    rc(1'b1, 12'h004, 4'he, 32'h0);
    rc(1'b0, 12'h008, 4'hf, 32'h0);
    check("unmapped", rv, 32'h0);
    check("cmd_be", {fwde, meme, ioe}, 32'h7);
    // every command value against every kind, window hit, valid and posting
    for (int c = 0; c < 8; c++) begin
      rc(1'b1, 12'h004, 4'h1, 32'(c));
      check("en", {fwde, meme, ioe}, 32'(c));
      for (int k = 0; k < 5; k++) begin
        for (int m = 0; m < 16; m++) begin
          @(posedge core_clk_i);
          #1;
          pk = bic_pkg::bic_req_e'(k);
          {pv, pio, pmem, unp} = m[3:0];
          uv = pv;
          #1;
          check("claim", claim, pv && ((k == 1 && pio && c[0]) || (k == 0 && pmem && c[1])));
          check("fwd", fwd, uv && (k > 2 || c[2]));
          check("ur", ur, uv && k < 3 && !c[2]);
          check("ur_cpl", urc, uv && unp && k < 3 && !c[2]);
        end
      end
    end
    @(posedge core_clk_i);
    #1 srst_i = 1'b1;
    @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    check("en_rst2", {fwde, meme, ioe}, 32'h0);
    rc(1'b0, 12'h004, 4'hf, 32'h0);
    check("cmd_rst2", rv, 32'h0);
    end_of_test();
  end
endmodule
